//--- logic/busy_timeout.sv
`timescale 1ns/100ps
`default_nettype none
`include "card_bus_defs.svh"
// Counts serial clock edges while the card is busy and flags an overrun.
module busy_timeout #(
    parameter int CNT_W = 6
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Serial clock rising-edge enable and busy level.
    input wire logic sclk_rise,
    input wire logic busy,
    // Timeout setting; zero disables detection.
    input wire logic [2:0] setting,
    // One-cycle pulse when busy exceeds the limit.
    output logic expired
);
    // The largest limit, seven times four plus two, needs five bits.
    if (CNT_W < 5) begin : g_bad_width
        $error("busy_timeout: counter too narrow");
    end

    logic [CNT_W-1:0] count_r; // Serial clocks spent busy.
    logic fired_r; // Blocks a second pulse in one busy period.
    logic [CNT_W-1:0] limit; // Setting times four plus two.

    assign limit = CNT_W'((setting << `CB_BUSY_MUL) + `CB_BUSY_ADD);

    // Counting only on sampled edges keeps the count in serial clock units.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            fired_r <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (!busy) begin
                count_r <= '0;
                fired_r <= 1'b0;
            end else if (sclk_rise && setting != 3'h0 && !fired_r) begin
                if (count_r == limit) begin
                    expired <= 1'b1;
                    fired_r <= 1'b1;
                end else begin
                    count_r <= count_r + 1'b1;
                end
            end
        end
    end
endmodule : busy_timeout
`default_nettype wire

//--- logic/card_bus_defs.svh
`ifndef CARD_BUS_DEFS_SVH
`define CARD_BUS_DEFS_SVH

// Register byte offsets.
`define CB_ADDR_W 8
`define CB_OFF_CONFIG 8'h60
`define CB_OFF_COMMAND 8'h64
`define CB_OFF_FOLLOWUP 8'h68
`define CB_OFF_STATUS 8'h6c
`define CB_OFF_IRQ 8'h70

// Configuration fields.
`define CB_CFG_SIE 0
`define CB_CFG_BUSY_LO 1
`define CB_CFG_BUSY_HI 3
`define CB_CFG_PMODE 15
`define CB_CFG_BUSY_RST 3'h5

// Command and follow-up fields.
`define CB_PID_LO 12
`define CB_PID_HI 15
`define CB_SIZE_LO 0
`define CB_SIZE_HI 8
`define CB_FU_EN 0
`define CB_FU_SIZE_LO 1
`define CB_FU_SIZE_HI 9
`define CB_FU_SIZE_RST 9'h001
`define CB_FU_PID_RST 4'h7

// Status bit positions.
`define CB_ST_DONE 0
`define CB_ST_CINT 1
`define CB_ST_TOUT 2
`define CB_ST_CRC 3
`define CB_ST_HSK 4
`define CB_ST_FLAG_LO 12
`define CB_ST_FLAG_HI 15

// Busy timeout is setting times four plus two serial clocks.
`define CB_BUSY_MUL 2
`define CB_BUSY_ADD 2

`endif

//--- logic/card_bus_pkg.sv
package card_bus_pkg;
    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PRIMARY = 4'h2,
        ST_WAIT_INT = 4'h4,
        ST_FOLLOW = 4'h8
    } seq_state_e;
    typedef logic [15:0] reg_word_t;
endpackage : card_bus_pkg

//--- logic/card_host_status_autocmd.sv
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "card_bus_defs.svh"
// Status and follow-up command logic of the card bus host controller.
module card_host_status_autocmd (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [`CB_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output card_bus_pkg::reg_word_t reg_rdata,
    // Card bus pins, asynchronous to clk.
    input wire logic sclk_pin,
    input wire logic card_int_pin,
    input wire logic card_busy_pin,
    input wire logic [3:0] card_dat_pin,
    output logic bus_state_line,
    // Transfer engine request and results, on clk.
    output logic txn_start,
    output logic [7:0] transfer_protocol_code,
    output logic [8:0] txn_byte_count,
    input wire logic txn_end,
    input wire logic txn_crc_error,
    input wire logic txn_handshake,
    // Configuration seen by the rest of the controller.
    output logic serial_if_enable,
    output logic parallel_mode
);
    import card_bus_pkg::*;

    // Synchronised pins.
    logic sclk_s; // Serial clock level.
    logic int_s; // Card interrupt level.
    logic busy_s; // Card busy level.
    logic [3:0] dat_s; // Data lines.

    pin_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in({sclk_pin, card_int_pin, card_busy_pin, card_dat_pin}),
        .pin_sync_out({sclk_s, int_s, busy_s, dat_s})
    );

    // Edge finders on the synchronised copies.
    logic sclk_d_r; // Previous serial clock level.
    logic int_d_r; // Previous interrupt level.
    logic sclk_rise; // Serial clock rising edge.
    logic int_rise; // Card interrupt onset.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
            int_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            int_d_r <= int_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_r;
    assign int_rise = int_s & ~int_d_r;

    // Register decode.
    logic wr_cfg; // Configuration write.
    logic wr_cmd; // Command write, which also clears status.
    logic wr_fu; // Follow-up register write.
    logic rd_irq; // Controller interrupt register read.

    assign wr_cfg = reg_wr && reg_addr == `CB_OFF_CONFIG;
    assign wr_cmd = reg_wr && reg_addr == `CB_OFF_COMMAND;
    assign wr_fu = reg_wr && reg_addr == `CB_OFF_FOLLOWUP;
    assign rd_irq = reg_rd && reg_addr == `CB_OFF_IRQ;

    // Configuration register.
    logic [2:0] busy_setting_r; // Busy timeout setting.

    // Software clears the interface enable around clock changes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_if_enable <= 1'b0;
            parallel_mode <= 1'b0;
            busy_setting_r <= `CB_CFG_BUSY_RST;
        end else if (wr_cfg) begin
            serial_if_enable <= reg_wdata[`CB_CFG_SIE];
            parallel_mode <= reg_wdata[`CB_CFG_PMODE];
            busy_setting_r <= reg_wdata[`CB_CFG_BUSY_HI:`CB_CFG_BUSY_LO];
        end
    end

    // Command register contents.
    logic [3:0] cmd_pid_r; // Primary protocol identifier.
    logic [8:0] cmd_size_r; // Primary byte count.

    // The command register only stores; launching is the sequencer's job.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_pid_r <= 4'h0;
            cmd_size_r <= 9'h000;
        end else if (wr_cmd) begin
            cmd_pid_r <= reg_wdata[`CB_PID_HI:`CB_PID_LO];
            cmd_size_r <= reg_wdata[`CB_SIZE_HI:`CB_SIZE_LO];
        end
    end

    // Follow-up command register.
    logic fu_enable_r; // Follow-up armed.
    logic [8:0] fu_size_r; // Follow-up byte count.
    logic [3:0] fu_pid_r; // Follow-up protocol identifier.
    logic fu_launch; // Follow-up launched this cycle.

    // A software write in the launch cycle wins, so a fresh arm is not lost.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fu_enable_r <= 1'b0;
            fu_size_r <= `CB_FU_SIZE_RST;
            fu_pid_r <= `CB_FU_PID_RST;
        end else if (wr_fu) begin
            fu_enable_r <= reg_wdata[`CB_FU_EN];
            fu_size_r <= reg_wdata[`CB_FU_SIZE_HI:`CB_FU_SIZE_LO];
            fu_pid_r <= reg_wdata[`CB_PID_HI:`CB_PID_LO];
        end else if (fu_launch) begin
            fu_enable_r <= 1'b0;
        end
    end

    // Sequencer for the primary and follow-up transactions.
    seq_state_e state_r; // Current phase.
    logic primary_done; // Primary ended with no follow-up pending.
    logic follow_done; // Follow-up finished.
    logic timeout_hit; // Busy timeout pulse.

    assign fu_launch = state_r == ST_WAIT_INT && int_rise;
    assign primary_done = state_r == ST_PRIMARY && txn_end && !fu_enable_r;
    assign follow_done = state_r == ST_FOLLOW && txn_end;

    // A new command while busy restarts the sequence; software should not do it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else if (wr_cmd && serial_if_enable) begin
            state_r <= ST_PRIMARY;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    state_r <= ST_IDLE;
                end
                ST_PRIMARY: begin
                    if (timeout_hit) begin
                        state_r <= ST_IDLE;
                    end else if (txn_end) begin
                        state_r <= fu_enable_r ? ST_WAIT_INT : ST_IDLE;
                    end
                end
                ST_WAIT_INT: begin
                    if (int_rise) begin
                        state_r <= ST_FOLLOW;
                    end
                end
                ST_FOLLOW: begin
                    if (txn_end || timeout_hit) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Launch requests to the transfer engine.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txn_start <= 1'b0;
            transfer_protocol_code <= 8'h00;
            txn_byte_count <= 9'h000;
        end else begin
            txn_start <= 1'b0;
            if (wr_cmd && serial_if_enable) begin
                txn_start <= 1'b1;
                transfer_protocol_code <= {reg_wdata[`CB_PID_HI:`CB_PID_LO],
                    ~reg_wdata[`CB_PID_HI:`CB_PID_LO]};
                txn_byte_count <= reg_wdata[`CB_SIZE_HI:`CB_SIZE_LO];
            end else if (fu_launch) begin
                txn_start <= 1'b1;
                transfer_protocol_code <= {fu_pid_r, ~fu_pid_r};
                txn_byte_count <= fu_size_r;
            end
        end
    end

    // Busy timeout measured in serial clock cycles.
    logic busy_expired; // Pulse from the counter.

    busy_timeout #(
        .CNT_W(6)
    ) u_busy (
        .clk(clk),
        .rst_n(rst_n),
        .sclk_rise(sclk_rise),
        .busy(busy_s && state_r != ST_IDLE),
        .setting(busy_setting_r),
        .expired(busy_expired)
    );

    assign timeout_hit = busy_expired;

    // Bus state line: high while a transaction runs, pulled low on timeout.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_line <= 1'b0;
        end else if (timeout_hit) begin
            bus_state_line <= 1'b0;
        end else begin
            bus_state_line <= (wr_cmd && serial_if_enable) || fu_launch
                || (state_r != ST_IDLE && !txn_end);
        end
    end

    // Gate that keeps the card interrupt bit quiet until the irq read.
    logic irq_seen_r; // Controller interrupt register read since last command.

    // The read sets the gate, so a read in the command cycle still counts.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_seen_r <= 1'b0;
        end else if (rd_irq) begin
            irq_seen_r <= 1'b1;
        end else if (wr_cmd) begin
            irq_seen_r <= 1'b0;
        end
    end

    // Sticky status flags; each event beats a same-cycle command clear.
    logic done_r; // Transaction ended.
    logic tout_r; // Busy timeout error.
    logic crc_r; // Read CRC error.
    logic hsk_r; // Handshake seen.
    logic [3:0] flags_r; // Parallel flags: end, error, request, nack.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'b1;
        end else if (primary_done || follow_done || timeout_hit || txn_crc_error) begin
            done_r <= 1'b1;
        end else if (wr_cmd) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tout_r <= 1'b0;
            crc_r <= 1'b0;
            hsk_r <= 1'b0;
        end else begin
            tout_r <= timeout_hit | (tout_r & ~wr_cmd);
            crc_r <= txn_crc_error | (crc_r & ~wr_cmd);
            hsk_r <= txn_handshake | (hsk_r & ~wr_cmd);
        end
    end

    // Data lines are captured at interrupt onset, only in parallel mode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= 4'h0;
        end else if (int_rise && parallel_mode) begin
            flags_r <= dat_s;
        end else if (wr_cmd) begin
            flags_r <= 4'h0;
        end
    end

    // Card interrupt bit, kept apart from the done bit.
    logic cint; // Live card interrupt indication.

    assign cint = irq_seen_r && (int_s || (parallel_mode && |flags_r));

    // Read data; only a controller interrupt register read changes status, by opening the card interrupt gate.
    reg_word_t status_word; // Assembled status.

    always_comb begin
        status_word = 16'h0000;
        status_word[`CB_ST_DONE] = done_r;
        status_word[`CB_ST_CINT] = cint;
        status_word[`CB_ST_TOUT] = tout_r;
        status_word[`CB_ST_CRC] = crc_r;
        status_word[`CB_ST_HSK] = hsk_r;
        status_word[`CB_ST_FLAG_HI:`CB_ST_FLAG_LO] = flags_r;
    end

    // Unmapped addresses read zero; data stand in the cycle after the strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `CB_OFF_CONFIG: begin
                    reg_rdata <= {parallel_mode, 11'h000, busy_setting_r, serial_if_enable};
                end
                `CB_OFF_COMMAND: begin
                    reg_rdata <= {cmd_pid_r, 3'h0, cmd_size_r};
                end
                `CB_OFF_FOLLOWUP: begin
                    reg_rdata <= {fu_pid_r, 2'h0, fu_size_r, fu_enable_r};
                end
                `CB_OFF_STATUS: begin
                    reg_rdata <= status_word;
                end
                `CB_OFF_IRQ: begin
                    reg_rdata <= {15'h0000, int_s};
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Power-down release is handled outside this block.
endmodule : card_host_status_autocmd
`default_nettype wire

//--- logic/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for pins from outside the clock domain.
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Raw pins and synchronised copy.
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);
    // A zero-width bundle has nothing to carry.
    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync: width must be at least one");
    end

    logic [WIDTH-1:0] meta_r; // First stage, read only by the second.

    // The first stage may go metastable, so only the second stage is used.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            pin_sync_out <= '0;
        end else begin
            meta_r <= pin_in;
            pin_sync_out <= meta_r;
        end
    end
endmodule : pin_sync
`default_nettype wire

//--- test/card_host_status_autocmd_bench.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench: register master, card stand-in, one task per scenario.
module card_host_status_autocmd_bench;
    import card_bus_pkg::*;
    logic clk, rst_n, reg_wr, reg_rd, sclk_pin, card_int_pin, card_busy_pin;
    logic bus_state_line, txn_start, txn_end, txn_crc_error, txn_handshake;
    logic serial_if_enable, parallel_mode, int_lvl;
    logic [7:0] reg_addr, transfer_protocol_code, last_code;
    logic [15:0] reg_wdata;
    reg_word_t reg_rdata;
    logic [3:0] card_dat_pin, flags;
    logic [8:0] txn_byte_count, last_cnt;
    logic [1:0] mode;
    int err_count, total_checks, starts; // Starts seen on the engine request.
    card_host_status_autocmd DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sclk_pin(sclk_pin), .card_int_pin(card_int_pin), .card_busy_pin(card_busy_pin),
        .card_dat_pin(card_dat_pin), .bus_state_line(bus_state_line),
        .txn_start(txn_start), .transfer_protocol_code(transfer_protocol_code),
        .txn_byte_count(txn_byte_count), .txn_end(txn_end), .txn_crc_error(txn_crc_error),
        .txn_handshake(txn_handshake), .serial_if_enable(serial_if_enable),
        .parallel_mode(parallel_mode));
    card_model u_card (.clk(clk), .rst_n(rst_n), .txn_start(txn_start), .mode(mode),
        .int_lvl(int_lvl), .flags(flags), .sclk_pin(sclk_pin), .card_int_pin(card_int_pin),
        .card_busy_pin(card_busy_pin), .card_dat_pin(card_dat_pin), .txn_end(txn_end),
        .txn_crc_error(txn_crc_error), .txn_handshake(txn_handshake));
    // Clock of 10 ns.
    always #5 clk = ~clk;
    // Record each start pulse with the code and count it carried.
    always @(posedge clk) begin
        if (txn_start === 1'b1) begin
            starts++;
            last_code = transfer_protocol_code;
            last_cnt = txn_byte_count;
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stands only in the cycle after the strobe.
    task automatic rd_raw(input logic [7:0] a, output logic [15:0] got);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask : rd_raw
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
        logic [15:0] g;
        rd_raw(a, g);
        chk(what, exp, g);
    endtask : rd
    // Poll the done bit under a bounded count, as software must before a command.
    task automatic wait_done;
        logic [15:0] g;
        g = 16'h0000;
        for (int i = 0; i < 400 && g[0] !== 1'b1; i++) rd_raw(8'h6c, g);
        chk("done poll", 16'h0001, {15'h0000, g[0]});
    endtask : wait_done
    task automatic t_reset;
        rd(8'h68, 16'h7002, "followup reset");
        rd(8'h6c, 16'h0001, "status reset");
        rd(8'h7e, 16'h0000, "unmapped read");
        $display("test reset values done");
    endtask : t_reset
    task automatic t_basic;
        wr(8'h60, 16'h000b);
        mode <= 2'h1;
        wr(8'h64, 16'ha005);
        rd(8'h6c, 16'h0000, "status after command");
        chk("code", 16'h00a5, {8'h00, last_code});
        chk("count", 16'h0005, {7'h00, last_cnt});
        wait_done();
        rd(8'h6c, 16'h0011, "status end handshake");
        rd(8'h6c, 16'h0011, "status reread");
        chk("bus state idle", 16'h0000, {15'h0000, bus_state_line});
        mode <= 2'h2;
        wr(8'h64, 16'h1003);
        wait_done();
        rd(8'h6c, 16'h0009, "status crc");
        $display("test command end handshake crc done");
    endtask : t_basic
    task automatic t_tout;
        int s0;
        wr(8'h60, 16'h0003);
        mode <= 2'h3;
        wr(8'h64, 16'h2001);
        wait_done();
        rd(8'h6c, 16'h0005, "status timeout");
        chk("bus state after timeout", 16'h0000, {15'h0000, bus_state_line});
        repeat (1040) @(posedge clk);
        mode <= 2'h0;
        wr(8'h60, 16'h000a);
        s0 = starts;
        wr(8'h64, 16'h2001);
        rd(8'h6c, 16'h0000, "status cleared");
        chk("no start while off", 16'(s0), 16'(starts));
        $display("test busy timeout done");
    endtask : t_tout
    task automatic t_follow;
        int s0;
        wr(8'h60, 16'h000b);
        wr(8'h68, 16'h3009);
        s0 = starts;
        wr(8'h64, 16'h8002);
        repeat (90) @(posedge clk);
        rd(8'h6c, 16'h0000, "done withheld");
        rd(8'h70, 16'h0000, "irq reg idle");
        int_lvl <= 1'b1;
        repeat (8) @(posedge clk);
        chk("followup starts", 16'(s0 + 2), 16'(starts));
        chk("followup code", 16'h003c, {8'h00, last_code});
        chk("followup count", 16'h0004, {7'h00, last_cnt});
        rd(8'h68, 16'h3008, "enable self clear");
        wait_done();
        rd(8'h6c, 16'h0003, "status serial int");
        int_lvl <= 1'b0;
        $display("test followup done");
    endtask : t_follow
    task automatic t_par;
        wr(8'h60, 16'h800b);
        flags <= 4'ha;
        wr(8'h64, 16'h1001);
        wait_done();
        rd(8'h6c, 16'h0001, "parallel done");
        int_lvl <= 1'b1;
        repeat (6) @(posedge clk);
        rd(8'h6c, 16'ha001, "flags gate shut");
        rd(8'h70, 16'h0001, "irq reg int");
        rd(8'h6c, 16'ha003, "flags gate open");
        int_lvl <= 1'b0;
        repeat (6) @(posedge clk);
        // Captured flags keep the bit up in parallel mode; serial mode shows the pin alone.
        rd(8'h6c, 16'ha003, "flags hold int");
        wr(8'h60, 16'h000b);
        rd(8'h6c, 16'ha001, "int released");
        $display("test parallel flags done");
    endtask : t_par
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // Main sequence after an eight-cycle reset.
    initial begin
        {clk, rst_n, reg_wr, reg_rd, int_lvl} = 5'h00;
        {reg_addr, reg_wdata, flags, mode} = 30'h0;
        err_count = 0;
        total_checks = 0;
        starts = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_basic();
        t_tout();
        t_follow();
        t_par();
        report_and_stop();
    end
    // Watchdog well past the expected run of some 2000 cycles.
    initial begin
        #300000;
        err_count++;
        report_and_stop();
    end
endmodule : card_host_status_autocmd_bench
`default_nettype wire

//--- test/card_host_status_autocmd_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "card_bus_defs.svh"
// Port-level checks of the status and follow-up logic.
module card_host_status_autocmd_monitor (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [`CB_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire card_bus_pkg::reg_word_t reg_rdata,
    // Card side.
    input wire logic card_busy_pin,
    input wire logic bus_state_line,
    // Transfer request.
    input wire logic txn_start,
    input wire logic [7:0] transfer_protocol_code,
    input wire logic [8:0] txn_byte_count,
    // Configuration.
    input wire logic serial_if_enable,
    input wire logic parallel_mode
);
    import card_bus_pkg::*;
    logic [2:0] busy_set_r; // Shadow of the timeout setting.
    logic [9:0] busy_cnt_r; // Clocks of unbroken busy, saturating.
    // Track the timeout setting from configuration writes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_set_r <= `CB_CFG_BUSY_RST;
        end else if (reg_wr && (reg_addr == `CB_OFF_CONFIG)) begin
            busy_set_r <= reg_wdata[3:1];
        end
    end
    // Count busy; 600 clocks exceeds the longest limit with sync slack.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_r <= 10'h000;
        end else if (!card_busy_pin) begin
            busy_cnt_r <= 10'h000;
        end else if (busy_cnt_r != 10'h258) begin
            busy_cnt_r <= busy_cnt_r + 10'h001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence cmd_write;
        reg_wr && (reg_addr == `CB_OFF_COMMAND);
    endsequence
    sequence cmd_go;
        reg_wr && (reg_addr == `CB_OFF_COMMAND) && serial_if_enable;
    endsequence
    sequence status_read;
        reg_rd && (reg_addr == `CB_OFF_STATUS);
    endsequence
    a_code_inverse: assert property (
        txn_start |-> transfer_protocol_code[3:0] == ~transfer_protocol_code[7:4])
        else $error("protocol code halves not inverse");
    a_code_from_cmd: assert property (cmd_go |=> txn_start &&
        transfer_protocol_code == {$past(reg_wdata[15:12]), ~$past(reg_wdata[15:12])}
        && txn_byte_count == $past(reg_wdata[8:0]))
        else $error("command write did not start with its code and count");
    a_cmd_off_idle: assert property (
        reg_wr && reg_addr == `CB_OFF_COMMAND && !serial_if_enable |=> !txn_start)
        else $error("start while serial interface off");
    a_start_single: assert property (txn_start |=> !txn_start)
        else $error("start pulse longer than one cycle");
    a_start_bus_high: assert property (txn_start |-> bus_state_line)
        else $error("bus state low during start");
    a_cmd_clears: assert property (
        cmd_write ##[1:2] status_read |=> reg_rdata == 16'h0000)
        else $error("status not cleared by command write");
    a_cfg_follow: assert property (
        reg_wr && reg_addr == `CB_OFF_CONFIG |=> serial_if_enable == $past(reg_wdata[0])
        && parallel_mode == $past(reg_wdata[15]))
        else $error("config outputs do not follow write");
    a_busy_timeout: assert property (
        busy_set_r != 3'h0 && busy_cnt_r == 10'h258 |-> !bus_state_line)
        else $error("bus state high after busy overrun");
endmodule : card_host_status_autocmd_monitor
bind card_host_status_autocmd card_host_status_autocmd_monitor u_monitor (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .card_busy_pin(card_busy_pin), .bus_state_line(bus_state_line),
    .txn_start(txn_start), .transfer_protocol_code(transfer_protocol_code),
    .txn_byte_count(txn_byte_count), .serial_if_enable(serial_if_enable),
    .parallel_mode(parallel_mode)
);
`default_nettype wire

//--- test/card_model.sv
`timescale 1ns/100ps
`default_nettype none
// Card and transfer engine stand-in; its serial clock runs only within a frame.
module card_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Engine request and bench controls.
    input wire logic txn_start,
    input wire logic [1:0] mode,
    input wire logic int_lvl,
    input wire logic [3:0] flags,
    // Card pins.
    output logic sclk_pin,
    output logic card_int_pin,
    output logic card_busy_pin,
    output logic [3:0] card_dat_pin,
    // Engine results.
    output logic txn_end,
    output logic txn_crc_error,
    output logic txn_handshake
);
    logic [9:0] cnt_r; // Clocks left in the current frame.
    logic last_r; // High in the final clock of a frame.
    assign last_r = (cnt_r == 10'h001);
    // Sixteen clocks per serial period gives 160 ns; low between frames.
    assign sclk_pin = (cnt_r != 10'h000) && cnt_r[3];
    // Mode 3 holds the card busy far past any timeout setting.
    assign card_busy_pin = (mode == 2'h3) && (cnt_r != 10'h000);
    // Flags sit on the data lines only with the interrupt, else their inverse.
    assign card_dat_pin = int_lvl ? flags : ~flags;
    assign card_int_pin = int_lvl;
    // Frame timing; a busy card never reports an end, so only a timeout frees the host.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 10'h000;
            txn_end <= 1'b0;
            txn_crc_error <= 1'b0;
            txn_handshake <= 1'b0;
        end else begin
            txn_end <= last_r && (mode != 2'h3);
            txn_crc_error <= last_r && (mode == 2'h2);
            txn_handshake <= last_r && (mode == 2'h1);
            if (txn_start) begin
                cnt_r <= (mode == 2'h3) ? 10'h3ff : 10'h040;
            end else if (cnt_r != 10'h000) begin
                cnt_r <= cnt_r - 10'h001;
            end
        end
    end
endmodule : card_model
`default_nettype wire
